//--- src/adc_result_pkg.sv
// Constants, carriers and decode helpers for the priority result and compare registers.
// Assumes one 200 MHz clock and a 32-bit AHB-Lite register bus with word-aligned registers.
//
// How it works
// R1: Priority result keeps bits 9:2 in 15:8, bits 1:0 in 7:6; 5:2 read zero.
// R2: Result-present flag in bit 0 sets on store, clears when low byte is read.
// R3: Overrun flag in bit 1 sets when a result replaces a not-fully-read one.
// R4: Reading the overrun flag clears it to zero.
// R5: Software reading bytewise reads the upper byte first, then the lower byte.
// R6: Software reads the result register with byte, halfword or word transfers.
// R7: Two writable 10-bit compare values, upper 15:8, lower 7:6, rest zero, reset zero.
// R8: Software changes a compare value only while its monitor enable is zero.
// R9: Priority conversion suspends normal conversion, completes, stores, then normal resumes.
// R10: Writes leave the result register and its flags untouched.
package adc_result_pkg;

  // Register byte offsets on the bus
  localparam logic [11:0] RESULT_OFFSET = 12'h000;
  localparam logic [11:0] COMPARE_A_OFFSET = 12'h004;
  localparam logic [11:0] COMPARE_B_OFFSET = 12'h008;

  // Field positions inside each 16-bit register
  localparam int VALUE_HI_MSB = 15;
  localparam int VALUE_HI_LSB = 8;
  localparam int VALUE_LO_MSB = 7;
  localparam int VALUE_LO_LSB = 6;
  localparam int OVERRUN_BIT = 1;
  localparam int PRESENT_BIT = 0;

  // Reset values
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] COMPARE_RESET = 10'h000;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic HRESP_OKAY = 1'h0;

  // Register selector for the data phase
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_RESULT = 2'h1,
    SEL_COMPARE_A = 2'h3,
    SEL_COMPARE_B = 2'h2
  } reg_sel_t;

  // Priority conversion sequencer states, Gray along idle-convert-resume
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_CONVERT = 2'h1,
    SEQ_RESUME = 2'h3
  } seq_state_t;

  // Conversion result handed over by the converter core
  typedef struct packed {
    logic done;
    logic [9:0] value;
  } conv_result_t;

  // Latched write data phase
  typedef struct packed {
    logic write;
    reg_sel_t sel;
    logic [3:0] lanes;
  } data_phase_t;

  // Byte lanes touched by a transfer of the given size at the given address
  function automatic logic [3:0] byte_lanes(input logic [2:0] size, input logic [1:0] lsb);
    logic [3:0] lanes;
    lanes = 4'hf;
    if (size == HSIZE_BYTE) begin
      lanes = 4'h1 << lsb;
    end else if (size == HSIZE_HALF) begin
      lanes = lsb[1] ? 4'hc : 4'h3;
    end
    return lanes;
  endfunction

  // Map a byte address to a register
  function automatic reg_sel_t decode_reg(input logic [11:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    case ({addr[11:2], 2'h0})
      RESULT_OFFSET: sel = SEL_RESULT;
      COMPARE_A_OFFSET: sel = SEL_COMPARE_A;
      COMPARE_B_OFFSET: sel = SEL_COMPARE_B;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

//--- src/compare_value_reg.sv
// One 10-bit monitor compare value with byte-lane writes.
// Assumes the bus slave gives a one-cycle write strobe with lanes and data already aligned.
`timescale 1ns/1ps
`default_nettype none
module compare_value_reg (
  input wire logic clock,
  input wire logic resetn,
  input wire logic write_strobe,
  input wire logic [1:0] lanes,
  input wire logic [15:0] wdata,
  input wire logic monitor_enable,
  output logic [9:0] value_q
);

  typedef struct packed {
    logic [9:0] value;
  } cmp_state_t;

  cmp_state_t s_q;
  cmp_state_t s_d;

  // Writes are dropped while the monitor compares, so it never sees a half-updated threshold
  always_comb begin
    s_d = s_q;
    if (write_strobe && !monitor_enable) begin
      if (lanes[1]) begin
        s_d.value[9:2] = wdata[adc_result_pkg::VALUE_HI_MSB:adc_result_pkg::VALUE_HI_LSB]; // see R7
      end
      if (lanes[0]) begin
        s_d.value[1:0] = wdata[adc_result_pkg::VALUE_LO_MSB:adc_result_pkg::VALUE_LO_LSB]; // see R7
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q.value <= adc_result_pkg::COMPARE_RESET; // see R7
    end else begin
      s_q <= s_d;
    end
  end

  assign value_q = s_q.value;

endmodule
`default_nettype wire

//--- src/priority_sequencer.sv
// Suspends normal conversion around one top-priority conversion and resumes it afterwards.
// Assumes the converter core pulses done once per started priority conversion.
`timescale 1ns/1ps
`default_nettype none
module priority_sequencer (
  input wire logic clock,
  input wire logic resetn,
  input wire logic priority_trigger,
  input wire logic core_done,
  output logic normal_suspend_q,
  output logic priority_start_q,
  output logic normal_resume_q,
  output logic converting_q
);

  typedef struct packed {
    adc_result_pkg::seq_state_t state;
    logic suspend;
    logic start;
    logic resume;
  } seq_reg_t;

  seq_reg_t s_q;
  seq_reg_t s_d;

  // Triggers during a running priority conversion are ignored, there is only one result slot
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.resume = 1'b0;
    unique case (s_q.state)
      adc_result_pkg::SEQ_IDLE: begin
        if (priority_trigger) begin
          s_d.state = adc_result_pkg::SEQ_CONVERT;
          s_d.suspend = 1'b1; // see R9
          s_d.start = 1'b1;
        end
      end
      adc_result_pkg::SEQ_CONVERT: begin
        if (core_done) begin
          s_d.state = adc_result_pkg::SEQ_RESUME;
          s_d.suspend = 1'b0;
          s_d.resume = 1'b1; // see R9
        end
      end
      adc_result_pkg::SEQ_RESUME: begin
        s_d.state = adc_result_pkg::SEQ_IDLE;
      end
      default: begin
        s_d.state = adc_result_pkg::SEQ_IDLE;
        s_d.suspend = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign normal_suspend_q = s_q.suspend;
  assign priority_start_q = s_q.start;
  assign normal_resume_q = s_q.resume;
  assign converting_q = (s_q.state == adc_result_pkg::SEQ_CONVERT);

endmodule
`default_nettype wire

//--- src/adc_priority_result_regs.sv
// Top of the priority result and monitor compare register slice, with its AHB-Lite slave.
// Assumes converter core, trigger and monitor enables run on the same clock as the bus.
`timescale 1ns/1ps
`default_nettype none
module adc_priority_result_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic priority_trigger,
  input wire logic core_done,
  input wire logic [9:0] core_value,
  input wire logic monitor_enable_a,
  input wire logic monitor_enable_b,
  output logic normal_suspend,
  output logic priority_start,
  output logic normal_resume,
  output logic [9:0] compare_value_a,
  output logic [9:0] compare_value_b,
  output logic priority_result_present_flag,
  output logic priority_overrun_flag
);

  // Whole state of the slave and the result register
  typedef struct packed {
    logic [9:0] result;
    logic present;
    logic overrun;
    logic upper_unread;
    adc_result_pkg::data_phase_t dp;
    logic [31:0] rdata;
    logic ready;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic accept;
  logic read_access;
  adc_result_pkg::reg_sel_t sel;
  logic [3:0] lanes;
  logic converting;
  logic store;
  logic clear_low;
  logic clear_high;
  logic [15:0] result_view;
  logic [9:0] cmp_a;
  logic [9:0] cmp_b;
  logic write_a;
  logic write_b;
  adc_result_pkg::conv_result_t conv;

  // Address phase decode; the slave never stalls so hready is always ours
  assign accept = hsel && (htrans == adc_result_pkg::HTRANS_NONSEQ) && hready;
  assign read_access = accept && !hwrite;
  assign sel = adc_result_pkg::decode_reg(haddr);
  assign lanes = adc_result_pkg::byte_lanes(hsize, haddr[1:0]);

  // Results only count while a priority conversion is actually running
  assign conv.done = core_done;
  assign conv.value = core_value;
  assign store = conv.done && converting;

  // Read side effects: the low byte carries both flags and the two low result bits
  assign clear_low = read_access && (sel == adc_result_pkg::SEL_RESULT) && lanes[0];
  assign clear_high = read_access && (sel == adc_result_pkg::SEL_RESULT) && lanes[1];

  // Register view of the result, reserved bits tied low
  always_comb begin
    result_view = 16'h0000;
    result_view[adc_result_pkg::VALUE_HI_MSB:adc_result_pkg::VALUE_HI_LSB] = s_q.result[9:2]; // see R1
    result_view[adc_result_pkg::VALUE_LO_MSB:adc_result_pkg::VALUE_LO_LSB] = s_q.result[1:0]; // see R1
    result_view[adc_result_pkg::OVERRUN_BIT] = s_q.overrun;
    result_view[adc_result_pkg::PRESENT_BIT] = s_q.present;
  end

  // Next state: read data is sampled in the address phase so side effects and data agree
  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b1;
    s_d.dp.write = accept && hwrite;
    s_d.dp.sel = sel;
    s_d.dp.lanes = lanes;
    if (read_access) begin
      unique case (sel)
        adc_result_pkg::SEL_RESULT: s_d.rdata = {16'h0000, result_view};
        adc_result_pkg::SEL_COMPARE_A: s_d.rdata = {16'h0000, cmp_a, 6'h00}; // see R7
        adc_result_pkg::SEL_COMPARE_B: s_d.rdata = {16'h0000, cmp_b, 6'h00}; // see R7
        adc_result_pkg::SEL_NONE: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Clears first, then a same-cycle store wins over them
    if (clear_low) begin
      s_d.present = 1'b0; // see R2
      s_d.overrun = 1'b0; // see R4
    end
    if (clear_high) begin
      s_d.upper_unread = 1'b0;
    end
    if (store) begin
      s_d.result = conv.value; // see R9
      s_d.present = 1'b1; // see R2
      s_d.upper_unread = 1'b1;
      if (s_q.present || s_q.upper_unread) begin
        s_d.overrun = 1'b1; // see R3
      end
    end
    // Writes to the result register fall through with no effect, see R10
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q.result <= adc_result_pkg::RESULT_RESET;
      s_q.present <= 1'b0;
      s_q.overrun <= 1'b0;
      s_q.upper_unread <= 1'b0;
      s_q.dp <= '0;
      s_q.rdata <= 32'h0000_0000;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Data phase write strobes; only the two compare registers take writes
  assign write_a = s_q.dp.write && (s_q.dp.sel == adc_result_pkg::SEL_COMPARE_A);
  assign write_b = s_q.dp.write && (s_q.dp.sel == adc_result_pkg::SEL_COMPARE_B);

  // Compare value A, frozen while monitor A runs
  compare_value_reg u_cmp_a (
    .clock(clock),
    .resetn(resetn),
    .write_strobe(write_a),
    .lanes(s_q.dp.lanes[1:0]),
    .wdata(hwdata[15:0]),
    .monitor_enable(monitor_enable_a), // see R8
    .value_q(cmp_a)
  );

  // Compare value B, frozen while monitor B runs
  compare_value_reg u_cmp_b (
    .clock(clock),
    .resetn(resetn),
    .write_strobe(write_b),
    .lanes(s_q.dp.lanes[1:0]),
    .wdata(hwdata[15:0]),
    .monitor_enable(monitor_enable_b), // see R8
    .value_q(cmp_b)
  );

  // Suspend and resume of normal conversion around a priority one
  priority_sequencer u_seq (
    .clock(clock),
    .resetn(resetn),
    .priority_trigger(priority_trigger),
    .core_done(core_done),
    .normal_suspend_q(normal_suspend),
    .priority_start_q(priority_start),
    .normal_resume_q(normal_resume),
    .converting_q(converting)
  );

  // Outputs straight from flops, hresp tied to OKAY
  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp = adc_result_pkg::HRESP_OKAY;
  assign compare_value_a = cmp_a;
  assign compare_value_b = cmp_b;
  assign priority_result_present_flag = s_q.present;
  assign priority_overrun_flag = s_q.overrun;

  // Checks beside the logic
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_store_sets_present: assert property ( // see R2
    store |=> s_q.present && s_q.result == $past(core_value))
    else $error("Stored result did not raise the present flag");

  a_low_read_clears: assert property ( // see R2
    clear_low && !store |=> !s_q.present ##1 (s_q.present == $past(store)))
    else $error("Low byte read did not clear the present flag");

  a_overrun_on_replace: assert property ( // see R3
    store && (s_q.present || s_q.upper_unread) |=> s_q.overrun)
    else $error("Replacing an unread result did not flag overrun");

  a_no_false_overrun: assert property ( // see R3
    store && !s_q.present && !s_q.upper_unread && !s_q.overrun |=> !s_q.overrun)
    else $error("Overrun raised with nothing pending");

  a_flag_read_clears: assert property ( // see R4
    clear_low && !store |=> !s_q.overrun)
    else $error("Reading the overrun flag did not clear it");

  a_result_layout: assert property ( // see R1
    read_access && sel == adc_result_pkg::SEL_RESULT |=>
      hrdata[15:6] == $past(s_q.result) && hrdata[5:2] == 4'h0 && hrdata[31:16] == 16'h0000)
    else $error("Result register read layout wrong");

  a_compare_layout: assert property ( // see R7
    read_access && sel == adc_result_pkg::SEL_COMPARE_B |=> hrdata[15:6] == $past(cmp_b) && hrdata[5:0] == 6'h00)
    else $error("Compare register read layout wrong");

  a_compare_frozen: assert property ( // see R8
    write_a && monitor_enable_a |=> $stable(cmp_a))
    else $error("Compare value changed while its monitor ran");

  a_result_write_ignored: assert property ( // see R10
    accept && hwrite && sel == adc_result_pkg::SEL_RESULT && !store && !clear_low |=>
      $stable(s_q.result) && $stable(s_q.present) && $stable(s_q.overrun))
    else $error("Write changed the result register");

  a_suspend_around: assert property ( // see R9
    priority_trigger && !normal_suspend && !converting && !normal_resume |=>
      normal_suspend && priority_start ##1 !priority_start)
    else $error("Priority trigger did not suspend normal conversion");

  a_resume_after: assert property ( // see R9
    store |=> normal_resume && !normal_suspend ##1 !normal_resume)
    else $error("Normal conversion not resumed after priority result");

  // Flags and result move only on a store or a low-lane read, never on their own
  a_present_steady: assert property ( // see R2
    !store && !clear_low |=> s_q.present == $past(s_q.present))
    else $error("Present flag moved with no store and no read");

  a_overrun_steady: assert property ( // see R3
    !store && !clear_low |=> s_q.overrun == $past(s_q.overrun))
    else $error("Overrun flag moved with no store and no read");

  a_result_steady: assert property ( // see R10
    !store |=> $stable(s_q.result))
    else $error("Result changed with no store");

  a_upper_read_marks: assert property ( // see R3
    clear_high && !store |=> !s_q.upper_unread)
    else $error("Upper byte read not recorded");

  a_flags_readback: assert property ( // see R2
    read_access && sel == adc_result_pkg::SEL_RESULT |=>
      hrdata[1:0] == $past({s_q.overrun, s_q.present}))
    else $error("Result flags read back wrong");

  // Compare values take exactly the written lanes while their monitor enable is low, and nothing else
  a_compare_a_layout: assert property ( // see R7
    read_access && sel == adc_result_pkg::SEL_COMPARE_A |=>
      hrdata[15:6] == $past(cmp_a) && hrdata[5:0] == 6'h00 && hrdata[31:16] == 16'h0000)
    else $error("Compare A read layout wrong");

  a_cmp_a_high: assert property ( // see R7
    write_a && !monitor_enable_a && s_q.dp.lanes[1] |=> cmp_a[9:2] == $past(hwdata[15:8]))
    else $error("Compare A upper bits did not land");

  a_cmp_a_low: assert property ( // see R7
    write_a && !monitor_enable_a && s_q.dp.lanes[0] |=> cmp_a[1:0] == $past(hwdata[7:6]))
    else $error("Compare A lower bits did not land");

  a_cmp_b_high: assert property ( // see R7
    write_b && !monitor_enable_b && s_q.dp.lanes[1] |=> cmp_b[9:2] == $past(hwdata[15:8]))
    else $error("Compare B upper bits did not land");

  a_cmp_b_low: assert property ( // see R7
    write_b && !monitor_enable_b && s_q.dp.lanes[0] |=> cmp_b[1:0] == $past(hwdata[7:6]))
    else $error("Compare B lower bits did not land");

  a_cmp_b_frozen: assert property ( // see R8
    write_b && monitor_enable_b |=> $stable(cmp_b))
    else $error("Compare value B changed while its monitor ran");

  a_compare_idle: assert property ( // see R7
    !write_a && !write_b |=> $stable(cmp_a) && $stable(cmp_b))
    else $error("Compare value changed with no write");

  a_suspend_holds: assert property ( // see R9
    converting && !core_done |=> converting && normal_suspend)
    else $error("Priority conversion dropped before its result");

  a_resume_on_store: assert property ( // see R9
    !store |=> !normal_resume)
    else $error("Normal conversion resumed without a priority result");

  a_start_single: assert property ( // see R9
    priority_start |=> !priority_start)
    else $error("Priority start lasted more than one cycle");

  a_bus_ready: assert property (
    hreadyout && hresp == adc_result_pkg::HRESP_OKAY)
    else $error("Slave stalled or answered with an error");

  c_store: cover property (store);
  c_priority_cycle: cover property (priority_start ##[1:300] normal_resume);
  c_overrun: cover property (store && s_q.present ##1 s_q.overrun);
  c_compare_write: cover property (write_a && !monitor_enable_a);
  c_bytewise_read: cover property (clear_high && !clear_low ##[1:4] clear_low && !clear_high);

endmodule
`default_nettype wire

//--- verif/converter_core_model.sv
// Behavioural converter core that answers priority start pulses with one done pulse.
// Assumes the bench sets the latency and the sample before it triggers a conversion.
`timescale 1ns/1ps
`default_nettype none
module converter_core_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic priority_start,
  input wire logic [7:0] latency,
  input wire logic [9:0] sample,
  output logic core_done,
  output logic [9:0] core_value
);
  logic busy_q;
  logic [7:0] count_q;

  // Value is only meaningful with done, so it toggles between results
  always @(posedge clock) begin
    core_done <= 1'b0;
    core_value <= ~core_value;
    if (!resetn) begin
      busy_q <= 1'b0;
      count_q <= 8'h00;
      core_value <= 10'h2aa;
    end else if (priority_start) begin
      busy_q <= 1'b1;
      count_q <= latency;
    end else if (busy_q) begin
      if (count_q == 8'h00) begin
        core_done <= 1'b1;
        core_value <= sample;
        busy_q <= 1'b0;
      end else begin
        count_q <= count_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the priority result and compare register slice.
// Assumes zero-wait AHB-Lite answers and a behavioural converter core on the far side.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic priority_trigger = 1'b0;
  logic core_done;
  logic [9:0] core_value;
  logic monitor_enable_a = 1'b0;
  logic monitor_enable_b = 1'b0;
  logic normal_suspend;
  logic priority_start;
  logic normal_resume;
  logic [9:0] compare_value_a;
  logic [9:0] compare_value_b;
  logic priority_result_present_flag;
  logic priority_overrun_flag;
  logic [7:0] latency = 8'h03;
  logic [9:0] sample = 10'h000;
  int miscompares = 0;
  int n_tests = 0;
  logic [31:0] rd;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  adc_priority_result_regs adc_priority_result_regs_inst (
    .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .priority_trigger(priority_trigger),
    .core_done(core_done), .core_value(core_value), .monitor_enable_a(monitor_enable_a),
    .monitor_enable_b(monitor_enable_b), .normal_suspend(normal_suspend),
    .priority_start(priority_start), .normal_resume(normal_resume),
    .compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
    .priority_result_present_flag(priority_result_present_flag),
    .priority_overrun_flag(priority_overrun_flag)
  );

  converter_core_model converter_core_model_inst (
    .clock(clock), .resetn(resetn), .priority_start(priority_start), .latency(latency),
    .sample(sample), .core_done(core_done), .core_value(core_value)
  );

  // One single transfer; holds each phase until hready is seen high at an edge
  // Only the watchdog ends a wait, so a stalled slave shows up as a failed run
  task automatic bus(input logic [11:0] a, input logic w, input logic [2:0] s,
                     input logic [31:0] wd, output logic [31:0] data);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= s;
    htrans <= 2'h2;
    do begin @(posedge clock); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clock); end while (hreadyout !== 1'b1);
    data = hrdata;
    `CHECK("hresp", 1'b0, hresp)
  endtask

  // Priority conversion of v; watches the suspend and resume handshake
  task automatic convert(input logic [9:0] v, input logic [7:0] lat);
    int n;
    n = 0;
    sample <= v;
    latency <= lat;
    priority_trigger <= 1'b1;
    @(posedge clock);
    priority_trigger <= 1'b0;
    #1;
    `CHECK("start", 1'b1, priority_start)
    @(posedge clock);
    #1;
    `CHECK("start end", 1'b0, priority_start)
    `CHECK("suspend", 1'b1, normal_suspend)
    while (normal_resume !== 1'b1 && n < 300) begin @(posedge clock); #1; n++; end
    `CHECK("resume", 1'b1, normal_resume)
    `CHECK("suspend end", 1'b0, normal_suspend)
    `CHECK("present pin", 1'b1, priority_result_present_flag)
    @(posedge clock);
    @(posedge clock);
  endtask

  function automatic logic [31:0] res_word(input logic [9:0] v, input logic ovr, input logic pres);
    return {16'h0000, v, 4'h0, ovr, pres};
  endfunction

  // Reset values and an unmapped place
  task automatic test_reset();
    bus(12'h000, 1'b0, 3'h2, 32'h0, rd);
    `CHECK("result rst", 32'h00000000, rd)
    bus(12'h004, 1'b0, 3'h2, 32'h0, rd);
    `CHECK("cmp a rst", 32'h00000000, rd)
    bus(12'h008, 1'b0, 3'h1, 32'h0, rd);
    `CHECK("cmp b rst", 32'h00000000, rd)
    bus(12'h00c, 1'b1, 3'h2, 32'hffffffff, rd);
    bus(12'h00c, 1'b0, 3'h2, 32'h0, rd);
    `CHECK("unmapped", 32'h00000000, rd)
    $display("reset test done");
  endtask

  // Store, ignored write, read clears present
  task automatic test_store();
    convert(10'h2d5, 8'h04);
    bus(12'h000, 1'b1, 3'h2, 32'h0000ffc3, rd);
    `CHECK("flags kept", 1'b1, priority_result_present_flag)
    bus(12'h000, 1'b0, 3'h2, 32'h0, rd);
    `CHECK("result", res_word(10'h2d5, 1'b0, 1'b1), rd)
    bus(12'h000, 1'b0, 3'h1, 32'h0, rd);
    `CHECK("present clr", res_word(10'h2d5, 1'b0, 1'b0), rd)
    `CHECK("present pin", 1'b0, priority_result_present_flag)
    $display("store test done");
  endtask

  // Two stores with no read between set the overrun flag; reading clears it
  task automatic test_overrun();
    convert(10'h13e, 8'h00);
    convert(10'h3c1, 8'h10);
    `CHECK("ovr pin", 1'b1, priority_overrun_flag)
    bus(12'h000, 1'b0, 3'h1, 32'h0, rd); // halfword takes upper and lower bytes together
    `CHECK("ovr set", res_word(10'h3c1, 1'b1, 1'b1), rd)
    bus(12'h000, 1'b0, 3'h2, 32'h0, rd);
    `CHECK("ovr clr", res_word(10'h3c1, 1'b0, 1'b0), rd)
    `CHECK("ovr pin clr", 1'b0, priority_overrun_flag)
    $display("overrun test done");
  endtask

  // Compare values written with monitors off, then held once monitors run
  task automatic test_compare();
    bus(12'h004, 1'b1, 3'h2, 32'hffffffff, rd);
    bus(12'h008, 1'b1, 3'h1, 32'h00005a40, rd);
    bus(12'h004, 1'b0, 3'h2, 32'h0, rd);
    `CHECK("cmp a", 32'h0000ffc0, rd)
    bus(12'h008, 1'b0, 3'h2, 32'h0, rd);
    `CHECK("cmp b", 32'h00005a40, rd)
    monitor_enable_a <= 1'b1;
    monitor_enable_b <= 1'b1;
    repeat (3) @(posedge clock);
    `CHECK("cmp a pin", 10'h3ff, compare_value_a)
    `CHECK("cmp b pin", 10'h169, compare_value_b)
    monitor_enable_a <= 1'b0;
    monitor_enable_b <= 1'b0;
    @(posedge clock);
    $display("compare test done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    test_reset();
    test_store();
    test_overrun();
    test_compare();
    give_verdict();
  end

  // Watchdog at 4000 cycles, well beyond the fewer than a hundred cycles the tests need
  initial begin
    #20000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
